/* File: core/sbfw_defs.svh */
// Offsets, field positions, reset values and counts of the sample buffer control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SBFW_DEFS_SVH
`define SBFW_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define SBFW_ADDR_BUF_CTRL2   8'h27
`define SBFW_RST_BUF_CTRL2    8'h00

// ****************************************************************
// Field positions of buffer_control_two
// ****************************************************************
`define SBFW_FLUSH_BIT        7
`define SBFW_WAKE_SRC_BIT     6
`define SBFW_WMRK_MSB         5
`define SBFW_WMRK_LSB         0

// ****************************************************************
// Buffer geometry and counter widths
// ****************************************************************
`define SBFW_DEPTH            32
`define SBFW_CNT_W            6
`define SBFW_GATE_CNT_W       5
`define SBFW_ASLP_W           8

`endif

/* File: core/sbfw_pkg.sv */
// Types shared by the sample buffer control block.
// Assumes sbfw_defs.svh is on the include path.
`include "sbfw_defs.svh"

package sbfw_pkg;

    // Buffer operating mode, driven from buffer_control_one outside this block.
    typedef enum logic [1:0]
    {
        SBFW_MODE_OFF     = 2'b00,
        SBFW_MODE_STREAM  = 2'b01,
        SBFW_MODE_STOP    = 2'b10,
        SBFW_MODE_TRIGGER = 2'b11
    } sbfw_mode_type;

    // One register access from the serial interface front end.
    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sbfw_reg_req_type;

    // Buffer status seen by the status and system mode registers.
    typedef struct packed
    {
        logic                          wmrk_flag;
        logic                          ovf_flag;
        logic [`SBFW_CNT_W-1:0]        cnt;
        logic                          gate_err;
        logic [`SBFW_GATE_CNT_W-1:0]   gate_cnt;
    } sbfw_status_type;

endpackage

/* File: core/sbfw_sleep_timer.sv */
// Auto-sleep timer: counts output data rate ticks while awake and drops to sleep.
// Assumes ticks and restarts arrive as one-cycle pulses on clk_sys.
`timescale 1ns/10ps
`include "sbfw_defs.svh"

module sbfw_sleep_timer
#(
    parameter int ASLP_W = `SBFW_ASLP_W
)
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              odr_tick,
    input  wire logic              restart,
    input  wire logic [ASLP_W-1:0] timeout,
    output logic                   wake_r
);

    logic [ASLP_W-1:0] ticks_r;

    // ****************************************************************
    // Tick counter
    // ****************************************************************

    // A restart always wins over a tick, so a cleared flag never loses to expiry.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            ticks_r <= '0;
        else if (restart)
            ticks_r <= '0;
        else if (odr_tick && wake_r && ticks_r != timeout)
            ticks_r <= ticks_r + 1'b1;
    end

    // ****************************************************************
    // Wake state
    // ****************************************************************

    // A zero timeout disables automatic sleep, so the part stays awake.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            wake_r <= 1'b1;
        else if (restart || timeout == '0)
            wake_r <= 1'b1;
        else if (odr_tick && ticks_r + 1'b1 == timeout)
            wake_r <= 1'b0;
    end

endmodule

/* File: core/sbfw_ctrl.sv */
// Sample buffer control: flush, watermark, triggered capture and wake source.
// Assumes a serial interface front end on clk_sys delivering one-cycle
// register strobes, and a sample store that follows the accept pulses.
`timescale 1ns/10ps
`include "sbfw_defs.svh"

module sbfw_ctrl
#(
    parameter int DEPTH  = `SBFW_DEPTH,
    parameter int CNT_W  = `SBFW_CNT_W,
    parameter int ASLP_W = `SBFW_ASLP_W
)
(
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire sbfw_pkg::sbfw_reg_req_type reg_req,
    output logic [7:0]                     reg_rdata_r,
    input  wire sbfw_pkg::sbfw_mode_type   buf_mode,
    input  wire logic                      sample_wr,
    input  wire logic                      sample_rd,
    input  wire logic                      trigger_pin,
    input  wire logic                      gate_err_set,
    input  wire logic                      gate_cnt_inc,
    input  wire logic                      odr_tick,
    input  wire logic                      other_activity,
    input  wire logic [ASLP_W-1:0]         auto_sleep_timeout_count,
    output logic                           sample_accept_r,
    output logic                           drop_oldest_r,
    output logic                           flush_pulse_r,
    output logic                           buf_activity_r,
    output logic                           wake_mode_r,
    output sbfw_pkg::sbfw_status_type      status_r
);

    // ****************************************************************
    // Declarations
    // ****************************************************************

    localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

    logic                 buffer_wake_source_enable_r;
    logic [5:0]           watermark_level_and_flag_r;
    logic                 trig_s1_r;
    logic                 trig_s2_r;
    logic                 trig_s3_r;
    logic                 triggered_r;
    logic                 halted_r;
    logic [CNT_W-1:0]     post_r;
    logic [CNT_W-1:0]     cnt_nxt;
    logic                 accept_nxt;
    logic                 drop_nxt;
    logic                 ovf_set;
    logic                 rd_ok;
    logic                 host_wr;
    logic                 trig_edge;
    logic                 wake_src_live;
    logic                 flags_clear_evt;
    logic                 restart_timer;
    logic                 timer_wake;
    logic [CNT_W-1:0]     wmrk;
    logic [CNT_W-1:0]     post_limit;
    logic                 mode_off;

    assign wmrk       = CNT_W'(watermark_level_and_flag_r);
    assign post_limit = FULL - wmrk;
    assign mode_off   = buf_mode == sbfw_pkg::SBFW_MODE_OFF;
    assign host_wr    = reg_req.wr && reg_req.addr == `SBFW_ADDR_BUF_CTRL2;
    assign rd_ok      = sample_rd && status_r.cnt != '0;
    assign trig_edge  = trig_s2_r && !trig_s3_r;

    // ****************************************************************
    // Register buffer_control_two
    // ****************************************************************

    // Writable level and wake source enable; the flush bit is never stored.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            buffer_wake_source_enable_r <= 1'(`SBFW_RST_BUF_CTRL2 >> `SBFW_WAKE_SRC_BIT);
            watermark_level_and_flag_r  <= '0;
        end
        else if (host_wr)
        begin
            buffer_wake_source_enable_r <= reg_req.wdata[`SBFW_WAKE_SRC_BIT];
            watermark_level_and_flag_r  <= reg_req.wdata[`SBFW_WMRK_MSB:`SBFW_WMRK_LSB];
        end
    end

    // flush self clears
    // Held for exactly one cycle, so no read can ever see it set.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            flush_pulse_r <= 1'b0;
        else
            flush_pulse_r <= host_wr && reg_req.wdata[`SBFW_FLUSH_BIT];
    end

    // read returns zero
    // Unmapped addresses read as zero; the flush position is always zero.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            reg_rdata_r <= '0;
        else if (reg_req.rd)
            reg_rdata_r <= (reg_req.addr == `SBFW_ADDR_BUF_CTRL2) ?
                {1'b0, buffer_wake_source_enable_r, watermark_level_and_flag_r} : 8'h00;
    end

    // ****************************************************************
    // Trigger pin synchroniser
    // ****************************************************************

    // The pin is asynchronous; the second and third stages feed the edge detector.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            {trig_s3_r, trig_s2_r, trig_s1_r} <= 3'b000;
        else
            {trig_s3_r, trig_s2_r, trig_s1_r} <= {trig_s2_r, trig_s1_r, trigger_pin};
    end

    // ****************************************************************
    // Next sample count
    // ****************************************************************

    // Decides acceptance, dropping of the oldest sample and overflow per mode.
    always_comb
    begin
        cnt_nxt    = status_r.cnt;
        accept_nxt = 1'b0;
        drop_nxt   = 1'b0;
        ovf_set    = 1'b0;
        if (flush_pulse_r || mode_off)
        begin
            cnt_nxt = '0;
        end
        else
        begin
            if (rd_ok)
                cnt_nxt = cnt_nxt - 1'b1;
            if (sample_wr)
            begin
                unique case (buf_mode)
                    sbfw_pkg::SBFW_MODE_STREAM:
                    begin
                        // Full stream buffer drops its oldest sample and overflows.
                        accept_nxt = 1'b1;
                        if (cnt_nxt == FULL)
                        begin
                            drop_nxt = 1'b1;
                            ovf_set  = 1'b1;
                        end
                        else
                            cnt_nxt = cnt_nxt + 1'b1;
                    end
                    sbfw_pkg::SBFW_MODE_STOP:
                    begin
                        if (cnt_nxt == FULL)
                            ovf_set = 1'b1;
                        else
                        begin
                            accept_nxt = 1'b1;
                            cnt_nxt    = cnt_nxt + 1'b1;
                        end
                    end
                    sbfw_pkg::SBFW_MODE_TRIGGER:
                    begin
                        if (!triggered_r)
                        begin
                            accept_nxt = 1'b1;
                            if (cnt_nxt >= wmrk)
                                drop_nxt = 1'b1;
                            else
                                cnt_nxt = cnt_nxt + 1'b1;
                        end
                        else if (!halted_r && cnt_nxt != FULL)
                        begin
                            accept_nxt = 1'b1;
                            cnt_nxt    = cnt_nxt + 1'b1;
                            ovf_set    = post_r + 1'b1 >= post_limit;
                        end
                    end
                    default: accept_nxt = 1'b0;
                endcase
            end
        end
    end

    // ****************************************************************
    // Triggered capture state
    // ****************************************************************

    // Re-armed only by a flush, an empty buffer or leaving triggered mode.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            triggered_r <= 1'b0;
            halted_r    <= 1'b0;
            post_r      <= '0;
        end
        else if (flush_pulse_r || buf_mode != sbfw_pkg::SBFW_MODE_TRIGGER ||
                 (rd_ok && cnt_nxt == '0))
        begin
            triggered_r <= 1'b0;
            halted_r    <= 1'b0;
            post_r      <= '0;
        end
        else if (!triggered_r)
        begin
            triggered_r <= trig_edge;
            halted_r    <= trig_edge && post_limit == '0;
        end
        else if (accept_nxt)
        begin
            post_r   <= post_r + 1'b1;
            halted_r <= ovf_set;
        end
    end

    // ****************************************************************
    // Status flags and count
    // ****************************************************************

    // One process owns the whole status word, so no field has a second driver.
    // A set in the clearing cycle is kept, so no event is lost.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            status_r <= '0;
        else
        begin
            status_r.cnt       <= cnt_nxt;
            status_r.wmrk_flag <= wmrk != '0 && cnt_nxt >= wmrk;
            if (ovf_set)
                status_r.ovf_flag <= 1'b1;
            else if (flush_pulse_r || mode_off || rd_ok)
                status_r.ovf_flag <= 1'b0;
            // flush clears gate fields
            // Also cleared when the host empties the buffer or disables it.
            if (gate_err_set)
                status_r.gate_err <= 1'b1;
            else if (flush_pulse_r || mode_off || (rd_ok && cnt_nxt == '0))
                status_r.gate_err <= 1'b0;
            if (gate_cnt_inc)
                status_r.gate_cnt <= status_r.gate_cnt + 1'b1;
            else if (flush_pulse_r || mode_off || (rd_ok && cnt_nxt == '0))
                status_r.gate_cnt <= '0;
        end
    end

    // Registered acknowledgements to the sample store.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            {sample_accept_r, drop_oldest_r} <= 2'b00;
        else
            {sample_accept_r, drop_oldest_r} <= {accept_nxt, drop_nxt};
    end

    // ****************************************************************
    // Auto wake and sleep coupling
    // ****************************************************************

    assign wake_src_live = buffer_wake_source_enable_r &&
        (buf_mode == sbfw_pkg::SBFW_MODE_STREAM || buf_mode == sbfw_pkg::SBFW_MODE_STOP);

    // clearing restarts timer
    // Independent of any interrupt enable; flags pending alone never restart.
    assign flags_clear_evt = wake_src_live &&
        (status_r.wmrk_flag || status_r.ovf_flag) && (flush_pulse_r || rd_ok);
    assign restart_timer = flags_clear_evt || other_activity;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            buf_activity_r <= 1'b0;
        else
            buf_activity_r <= wake_src_live && (status_r.wmrk_flag || status_r.ovf_flag);
    end

    sbfw_sleep_timer
    #(
        .ASLP_W (ASLP_W)
    )
    u_sleep_timer
    (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .odr_tick (odr_tick),
        .restart  (restart_timer),
        .timeout  (auto_sleep_timeout_count),
        .wake_r   (timer_wake)
    );

    // Output copy keeps every top-level output on a flop of this module.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            wake_mode_r <= 1'b1;
        else
            wake_mode_r <= timer_wake;
    end

endmodule

/* File: testbench/sbfw_ctrl_props.sv */
// Checker for the sample buffer control block ports.
// Assumes one clock domain and a bind onto every sbfw_ctrl.
`timescale 1ns/10ps

module sbfw_ctrl_props
#(
    parameter int DEPTH  = 32,
    parameter int CNT_W  = 6,
    parameter int ASLP_W = 8
)
(
    input wire logic                       clk_sys,
    input wire logic                       reset,
    input wire sbfw_pkg::sbfw_reg_req_type reg_req,
    input wire logic [7:0]                 reg_rdata_r,
    input wire sbfw_pkg::sbfw_mode_type    buf_mode,
    input wire logic                       sample_wr,
    input wire logic                       sample_rd,
    input wire logic                       trigger_pin,
    input wire logic                       gate_err_set,
    input wire logic                       gate_cnt_inc,
    input wire logic                       odr_tick,
    input wire logic                       other_activity,
    input wire logic [ASLP_W-1:0]          auto_sleep_timeout_count,
    input wire logic                       sample_accept_r,
    input wire logic                       drop_oldest_r,
    input wire logic                       flush_pulse_r,
    input wire logic                       buf_activity_r,
    input wire logic                       wake_mode_r,
    input wire sbfw_pkg::sbfw_status_type  status_r
);
    logic [5:0] level_r;
    logic       wake_en_r;
    wire        cfg_wr = reg_req.wr && reg_req.addr == 8'h27;
    wire        flush_req = cfg_wr && reg_req.wdata[7];
    wire        mode_ok = buf_mode == sbfw_pkg::SBFW_MODE_STREAM
                          || buf_mode == sbfw_pkg::SBFW_MODE_STOP;
    wire        flag_any = status_r.wmrk_flag || status_r.ovf_flag;
    wire        act_cond = wake_en_r && mode_ok && flag_any;

    // Shadow of the level and enable, since the checker cannot see the register.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            level_r <= 6'h00;
            wake_en_r <= 1'b0;
        end
        else if (cfg_wr)
        begin
            level_r <= reg_req.wdata[5:0];
            wake_en_r <= reg_req.wdata[6];
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_flush_cause: assert property (flush_pulse_r |-> $past(flush_req))
        else $error("flush pulse without a flush write");
    a_flush_one_pulse: assert property (flush_req |=> flush_pulse_r ##1 !flush_pulse_r)
        else $error("flush pulse not exactly one cycle");
    a_flush_empties: assert property
        (flush_pulse_r |=> status_r.cnt == 6'h00 && !status_r.wmrk_flag && !status_r.ovf_flag)
        else $error("flush left samples or watermark flag");
    a_flush_gate: assert property
        (flush_pulse_r && !gate_err_set && !gate_cnt_inc
         |=> !status_r.gate_err && status_r.gate_cnt == 5'h00)
        else $error("flush left gate fields set");
    a_rdata_no_flush: assert property (reg_rdata_r[7] == 1'b0)
        else $error("flush bit read back as one");
    a_wmrk_level: assert property
        ($rose(status_r.wmrk_flag) |-> level_r != 6'h00 && status_r.cnt >= level_r)
        else $error("watermark flag rose below level");
    a_activity_src: assert property (buf_activity_r == $past(act_cond))
        else $error("buffer activity does not follow flags");
    a_sleep_on_tick: assert property
        ($fell(wake_mode_r) |-> $past(odr_tick) || $past(odr_tick, 2) || $past(odr_tick, 3))
        else $error("sleep entered without a tick");
    a_flush_wakes: assert property
        (flush_pulse_r && act_cond |-> ##[1:3] wake_mode_r)
        else $error("flag clear did not keep the part awake");
    a_cnt_bound: assert property (status_r.cnt <= 6'(DEPTH))
        else $error("sample count beyond depth");
endmodule

bind sbfw_ctrl sbfw_ctrl_props #(.DEPTH(DEPTH), .CNT_W(CNT_W), .ASLP_W(ASLP_W)) u_props
(
    .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
    .buf_mode(buf_mode), .sample_wr(sample_wr), .sample_rd(sample_rd),
    .trigger_pin(trigger_pin), .gate_err_set(gate_err_set), .gate_cnt_inc(gate_cnt_inc),
    .odr_tick(odr_tick), .other_activity(other_activity),
    .auto_sleep_timeout_count(auto_sleep_timeout_count),
    .sample_accept_r(sample_accept_r), .drop_oldest_r(drop_oldest_r),
    .flush_pulse_r(flush_pulse_r), .buf_activity_r(buf_activity_r),
    .wake_mode_r(wake_mode_r), .status_r(status_r)
);

/* File: testbench/sbfw_host_model.sv */
// Host model: single-byte register writes and reads on the block's front end.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/10ps

module sbfw_host_model
(
    input  wire logic                 clk_sys,
    output sbfw_pkg::sbfw_reg_req_type reg_req,
    input  wire logic [7:0]           reg_rdata_r
);
    // Idle address and data are inverted so stale values are never trusted.
    initial reg_req = {1'b0, 1'b0, 8'hff, 8'hff};

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        reg_req = {1'b1, 1'b0, addr, data};
        @(posedge clk_sys);
        #1;
        reg_req = {1'b0, 1'b0, ~addr, ~data};
    endtask

    // Read data is taken one full cycle after the strobe edge.
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
        reg_req = {1'b0, 1'b1, addr, 8'h00};
        @(posedge clk_sys);
        #1;
        reg_req = {1'b0, 1'b0, ~addr, 8'hff};
        @(posedge clk_sys);
        #1;
        data = reg_rdata_r;
    endtask
endmodule

/* File: testbench/sample_buffer_flush_watermark_ctrl_tb.sv */
// Testbench for the sample buffer control block.
// Assumes the package, host model and checker are compiled before it.
`timescale 1ns/10ps

module sample_buffer_flush_watermark_ctrl_tb;
    logic                       clk_sys = 1'b0;
    logic                       reset = 1'b1;
    sbfw_pkg::sbfw_reg_req_type reg_req;
    logic [7:0]                 reg_rdata_r;
    sbfw_pkg::sbfw_mode_type    buf_mode = sbfw_pkg::SBFW_MODE_STREAM;
    logic                       sample_wr = 1'b0;
    logic                       sample_rd = 1'b0;
    logic                       trigger_pin = 1'b0;
    logic                       gate_err_set = 1'b0;
    logic                       gate_cnt_inc = 1'b0;
    logic                       odr_tick = 1'b0;
    logic                       other_activity = 1'b0;
    logic [7:0]                 timeout = 8'h00;
    logic                       sample_accept_r;
    logic                       drop_oldest_r;
    logic                       flush_pulse_r;
    logic                       buf_activity_r;
    logic                       wake_mode_r;
    sbfw_pkg::sbfw_status_type  status_r;
    logic [7:0]                 rd_val;
    int                         miscompares = 0;
    int                         tests_run = 0;

    always #20 clk_sys = ~clk_sys;

    sbfw_host_model u_host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r));

    sbfw_ctrl u_dut
    (
        .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
        .buf_mode(buf_mode), .sample_wr(sample_wr), .sample_rd(sample_rd),
        .trigger_pin(trigger_pin), .gate_err_set(gate_err_set), .gate_cnt_inc(gate_cnt_inc),
        .odr_tick(odr_tick), .other_activity(other_activity),
        .auto_sleep_timeout_count(timeout), .sample_accept_r(sample_accept_r),
        .drop_oldest_r(drop_oldest_r),
        .flush_pulse_r(flush_pulse_r), .buf_activity_r(buf_activity_r),
        .wake_mode_r(wake_mode_r), .status_r(status_r)
    );

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Every task starts and ends one nanosecond after a rising edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic samples(input int n);
        sample_wr = 1'b1;
        cyc(n);
        sample_wr = 1'b0;
        cyc(2);
    endtask

    task automatic t_regs();
        u_host.rd_reg(8'h27, rd_val);
        chk("reset value", 8'h00, rd_val);
        u_host.wr_reg(8'h27, 8'h45);
        // An edge passes so the host request is never driven twice in one step.
        cyc(1);
        u_host.rd_reg(8'h27, rd_val);
        chk("readback", 8'h45, rd_val);
        u_host.rd_reg(8'h30, rd_val);
        chk("unmapped", 8'h00, rd_val);
    endtask

    // Level zero first, then the exact boundary count equal to the level.
    task automatic t_wmrk();
        u_host.wr_reg(8'h27, 8'h80);
        cyc(1);
        samples(5);
        chk("wmrk off", 8'h00, 8'(status_r.wmrk_flag));
        u_host.wr_reg(8'h27, 8'h07);
        samples(1);
        chk("wmrk at 6", 8'h00, 8'(status_r.wmrk_flag));
        samples(1);
        chk("wmrk at 7", 8'h01, 8'(status_r.wmrk_flag));
    endtask

    task automatic t_flush();
        gate_err_set = 1'b1;
        gate_cnt_inc = 1'b1;
        cyc(1);
        gate_err_set = 1'b0;
        cyc(2);
        gate_cnt_inc = 1'b0;
        cyc(1);
        chk("gate cnt", 8'h03, 8'(status_r.gate_cnt));
        u_host.wr_reg(8'h27, 8'h87);
        chk("flush pulse", 8'h01, 8'(flush_pulse_r));
        cyc(2);
        chk("cnt", 8'h00, 8'(status_r.cnt));
        chk("wmrk", 8'h00, 8'(status_r.wmrk_flag));
        chk("gate", 8'h00, {2'b00, status_r.gate_err, status_r.gate_cnt});
        u_host.rd_reg(8'h27, rd_val);
        chk("flush reads", 8'h07, rd_val);
        samples(3);
        u_host.wr_reg(8'h27, 8'h87);
        sample_wr = 1'b1;
        cyc(1);
        sample_wr = 1'b0;
        chk("accept in flush", 8'h00, 8'(sample_accept_r));
        cyc(2);
        chk("cnt race", 8'h00, 8'(status_r.cnt));
    endtask

    // Pre-trigger cap, then 32 minus level more, then a halted buffer.
    task automatic t_trig();
        buf_mode = sbfw_pkg::SBFW_MODE_TRIGGER;
        u_host.wr_reg(8'h27, 8'h84);
        cyc(1);
        samples(6);
        chk("pre cnt", 8'h04, 8'(status_r.cnt));
        sample_wr = 1'b1;
        cyc(1);
        sample_wr = 1'b0;
        chk("pre drop", 8'h03, {6'h00, sample_accept_r, drop_oldest_r});
        trigger_pin = 1'b1;
        cyc(5);
        samples(28);
        chk("post cnt", 8'h20, 8'(status_r.cnt));
        chk("ovf", 8'h01, 8'(status_r.ovf_flag));
        samples(1);
        chk("halted", 8'h20, 8'(status_r.cnt));
        trigger_pin = 1'b0;
        sample_rd = 1'b1;
        cyc(1);
        sample_rd = 1'b0;
        cyc(2);
        chk("read one", 8'h1f, 8'(status_r.cnt));
    endtask

    task automatic t_sleep();
        buf_mode = sbfw_pkg::SBFW_MODE_STREAM;
        u_host.wr_reg(8'h27, 8'h81);
        cyc(1);
        samples(1);
        chk("act off", 8'h00, 8'(buf_activity_r));
        u_host.wr_reg(8'h27, 8'h41);
        cyc(2);
        chk("act on", 8'h01, 8'(buf_activity_r));
        timeout = 8'h02;
        repeat (4)
        begin
            odr_tick = 1'b1;
            cyc(1);
            odr_tick = 1'b0;
            cyc(2);
        end
        chk("asleep", 8'h00, 8'(wake_mode_r));
        u_host.wr_reg(8'h27, 8'hc1);
        cyc(3);
        chk("awake", 8'h01, 8'(wake_mode_r));
        samples(1);
        buf_mode = sbfw_pkg::SBFW_MODE_TRIGGER;
        cyc(2);
        chk("act trig", 8'h00, 8'(buf_activity_r));
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        t_regs();
        t_wmrk();
        t_flush();
        t_trig();
        t_sleep();
        end_of_test();
    end

    // The run needs about 140 cycles; this cuts a hang at 5000.
    initial
    begin
        #200000;
        miscompares++;
        end_of_test();
    end
endmodule
